// [verilog/pie_bank.sv]
// Interrupt enables, page choice and error counters behind an AHB-Lite slave
//
// Notes on behaviour
// - Counter modes both off: bit 8 flags receive-error half-full, cleared by read.
// - Either counter mode on: bit 8 flags control frame, cleared by read.
// - Enables 7,6,5,4,2 gate link quality, energy, link, speed, autoneg; reset 0.
// - Enable 3 gates duplex change, or time-protocol when interrupt mode is set.
// - Enable 1 gates false-carrier half-full, or either counter half-full.
// - Enable 0 gates receive-error half-full, or control frame.
// - Three-bit page choice selects bank for 14h-1Fh; 1 and 3 reserved; reset 0. The counters at 14h and 15h answer on every page.
// - Reserved upper bits of page and counter registers ignore writes, read 0.
// - False carrier counter counts events, sticks at FFh, clears on read.
// - Receive error counter counts invalid symbols during valid carrier, clears on read.
// - At most one receive error count per carrier; none during collision.
// - Receive error counter saturates at maximum until cleared.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "pie_cfg.svh"
module pie_bank (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Receive path events, from pins
	input wire logic false_carrier_pin,
	input wire logic rx_error_pin,
	input wire logic carrier_valid_pin,
	input wire logic collision_pin,
	input wire logic control_frame_pin,
	// Other interrupt sources, one-cycle pulses on hclk
	input wire logic link_quality_evt,
	input wire logic energy_detect_evt,
	input wire logic link_change_evt,
	input wire logic speed_change_evt,
	input wire logic duplex_change_evt,
	input wire logic time_protocol_evt,
	input wire logic autoneg_done_evt,
	// Steering and status
	output logic [2:0] bank_choice,
	output logic irq
);
	// Bus address phase capture
	logic wr_pend_q;
	logic [5:0] wr_idx_q;
	wire take = hsel && hready && htrans[1];
	wire [5:0] idx = haddr[7:2];
	wire rd_take = take && !hwrite;
	wire wr_take = take && hwrite;
	wire in_range = (haddr[31:8] == 24'h00_0000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 6'h00;
		end else begin
			wr_pend_q <= wr_take && in_range;
			wr_idx_q <= idx;
		end
	end

	// Pin synchronisers
	pie_pkg::pie_rx_evt_t rx_s;
	pie_event_sync u_sync_fc (.hclk(hclk), .hresetn(hresetn), .pin(false_carrier_pin),
		.level(rx_s.false_carrier));
	pie_event_sync u_sync_re (.hclk(hclk), .hresetn(hresetn), .pin(rx_error_pin),
		.level(rx_s.rx_error));
	pie_event_sync u_sync_cv (.hclk(hclk), .hresetn(hresetn), .pin(carrier_valid_pin),
		.level(rx_s.carrier_valid));
	pie_event_sync u_sync_co (.hclk(hclk), .hresetn(hresetn), .pin(collision_pin),
		.level(rx_s.collision));
	pie_event_sync u_sync_cf (.hclk(hclk), .hresetn(hresetn), .pin(control_frame_pin),
		.level(rx_s.control_frame));

	// Edge detect on synchronised levels
	logic fc_prev_q;
	logic cf_prev_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fc_prev_q <= 1'b0;
			cf_prev_q <= 1'b0;
		end else begin
			fc_prev_q <= rx_s.false_carrier;
			cf_prev_q <= rx_s.control_frame;
		end
	end
	wire fc_event = rx_s.false_carrier && !fc_prev_q;
	wire cf_event = rx_s.control_frame && !cf_prev_q;

	// One receive error per carrier, none while colliding
	pie_pkg::pie_carrier_st_t car_q;
	pie_pkg::pie_carrier_st_t car_d;
	wire re_event = (car_q == pie_pkg::PIE_CARRIER_OPEN) && rx_s.carrier_valid
		&& rx_s.rx_error && !rx_s.collision;
	always_comb begin
		car_d = car_q;
		unique case (car_q)
			pie_pkg::PIE_CARRIER_IDLE: begin
				if (rx_s.carrier_valid) begin
					car_d = pie_pkg::PIE_CARRIER_OPEN;
				end
			end
			pie_pkg::PIE_CARRIER_OPEN: begin
				if (!rx_s.carrier_valid) begin
					car_d = pie_pkg::PIE_CARRIER_IDLE;
				end else if (re_event) begin
					car_d = pie_pkg::PIE_CARRIER_USED;
				end
			end
			pie_pkg::PIE_CARRIER_USED: begin
				if (!rx_s.carrier_valid) begin
					car_d = pie_pkg::PIE_CARRIER_IDLE;
				end
			end
			default: car_d = pie_pkg::PIE_CARRIER_IDLE;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			car_q <= pie_pkg::PIE_CARRIER_IDLE;
		end else begin
			car_q <= car_d;
		end
	end

	// Counters, cleared by a read of their own register
	wire rd_fcc = rd_take && in_range && (idx == `PIE_IDX_FCC);
	wire rd_rec = rd_take && in_range && (idx == `PIE_IDX_REC);
	wire rd_isr = rd_take && in_range && (idx == `PIE_IDX_ISR);
	wire rd_istat = rd_take && in_range && (idx == `PIE_IDX_ISTAT);
	logic [7:0] fc_count;
	logic [7:0] re_count;
	logic fc_half;
	logic re_half;
	pie_sat_counter u_fcc (.hclk(hclk), .hresetn(hresetn), .inc(fc_event), .clr(rd_fcc),
		.count(fc_count), .half_rise(fc_half));
	pie_sat_counter u_rec (.hclk(hclk), .hresetn(hresetn), .inc(re_event), .clr(rd_rec),
		.count(re_count), .half_rise(re_half));

	// Configuration: counter modes, interrupt mode, control-frame config
	logic [`PIE_CFG_W-1:0] cfg_q;
	wire ctr_mode = cfg_q[1] || cfg_q[0];
	wire int_mode = cfg_q[2];
	wire cf_cfg = cfg_q[3] || ctr_mode;

	// Enables and page choice
	pie_pkg::pie_enable_t en_q;
	logic [2:0] bank_q;
	wire wr_isr = wr_pend_q && (wr_idx_q == `PIE_IDX_ISR);
	wire wr_bank = wr_pend_q && (wr_idx_q == `PIE_IDX_BANK);
	wire wr_cfg = wr_pend_q && (wr_idx_q == `PIE_IDX_CFG);
	wire wr_mask = wr_pend_q && (wr_idx_q == `PIE_IDX_IMASK);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= `PIE_ENABLE_RST;
			bank_q <= `PIE_BANK_RST;
			cfg_q <= 4'h0;
		end else begin
			if (wr_isr) begin
				en_q <= hwdata[7:0];
			end
			if (wr_bank) begin
				bank_q <= hwdata[2:0];
			end
			if (wr_cfg) begin
				cfg_q <= hwdata[3:0];
			end
		end
	end
	assign bank_choice = bank_q;

	// Pending flags, one per enable slot
	wire [7:0] raise;
	assign raise[7] = link_quality_evt;
	assign raise[6] = energy_detect_evt;
	assign raise[5] = link_change_evt;
	assign raise[4] = speed_change_evt;
	assign raise[3] = int_mode ? time_protocol_evt : duplex_change_evt;
	assign raise[2] = autoneg_done_evt;
	assign raise[1] = cf_cfg ? (fc_half || re_half) : fc_half;
	assign raise[0] = ctr_mode ? cf_event : re_half;

	logic [7:0] pend_q;
	logic [7:0] pend_d;
	// A new event in the reading cycle survives the clear
	assign pend_d = raise | (rd_isr ? 8'h00 : pend_q);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 8'h00;
		end else begin
			pend_q <= pend_d;
		end
	end

	// Separate sticky status of gated interrupts with its own mask
	logic [7:0] istat_q;
	logic [7:0] imask_q;
	wire [7:0] gated = pend_q & en_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			istat_q <= 8'h00;
			imask_q <= 8'h00;
		end else begin
			istat_q <= gated | (rd_istat ? 8'h00 : istat_q);
			if (wr_mask) begin
				imask_q <= hwdata[7:0];
			end
		end
	end
	assign irq = |gated || |(istat_q & ~imask_q);

	// Read data, registered for the data phase
	wire [15:0] isr_word = {7'h00, pend_q[0], en_q};
	wire [15:0] fcc_word = {8'h00, fc_count};
	wire [15:0] rec_word = {8'h00, re_count};
	wire [15:0] bank_word = {13'h0000, bank_q};
	wire [15:0] rd_mux =
		(idx == `PIE_IDX_ISR) ? isr_word :
		(idx == `PIE_IDX_FCC) ? fcc_word :
		(idx == `PIE_IDX_REC) ? rec_word :
		(idx == `PIE_IDX_BANK) ? bank_word :
		(idx == `PIE_IDX_CFG) ? {12'h000, cfg_q} :
		(idx == `PIE_IDX_EVT) ? {8'h00, pend_q} :
		(idx == `PIE_IDX_IMASK) ? {8'h00, imask_q} :
		(idx == `PIE_IDX_ISTAT) ? {8'h00, istat_q} : 16'h0000;
	logic [31:0] rdata_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_take) begin
			rdata_q <= in_range ? {16'h0000, rd_mux} : 32'h0000_0000;
		end
	end
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule : pie_bank

// [verilog/pie_cfg.svh]
// Register offsets, field positions and reset values of the interrupt, page and counter bank
`ifndef PIE_CFG_SVH
`define PIE_CFG_SVH
// Offsets are register indexes; the byte address is four times the index
`define PIE_IDX_ISR 6'h12
`define PIE_IDX_FCC 6'h14
`define PIE_IDX_REC 6'h15
`define PIE_IDX_BANK 6'h13
`define PIE_IDX_CFG 6'h20
`define PIE_IDX_EVT 6'h21
`define PIE_IDX_IMASK 6'h22
`define PIE_IDX_ISTAT 6'h23
`define PIE_ENABLE_RST 8'h00
`define PIE_BANK_RST 3'h0
`define PIE_CNT_MAX 8'hFF
`define PIE_CNT_HALF_BIT 7
`define PIE_STAT_BIT 8
`define PIE_BANK_EXT 3'h0
`define PIE_BANK_RSV1 3'h1
`define PIE_BANK_DIAG 3'h2
`define PIE_BANK_RSV3 3'h3
`define PIE_BANK_TPB 3'h4
`define PIE_BANK_TPC5 3'h5
`define PIE_BANK_TPC6 3'h6
`define PIE_CFG_W 4
`define PIE_IRQ_W 2
`endif

// [verilog/pie_pkg.sv]
// Types shared by the interrupt, page and counter bank
package pie_pkg;
	typedef struct packed {
		logic link_quality;
		logic energy_detect;
		logic link_change;
		logic speed_change;
		logic duplex_or_time;
		logic autoneg_done;
		logic false_carrier_half;
		logic rxerr_half;
	} pie_enable_t;

	typedef struct packed {
		logic false_carrier;
		logic rx_error;
		logic carrier_valid;
		logic collision;
		logic control_frame;
	} pie_rx_evt_t;

	typedef enum logic [1:0] {
		PIE_CARRIER_IDLE = 2'b00,
		PIE_CARRIER_OPEN = 2'b01,
		PIE_CARRIER_USED = 2'b10
	} pie_carrier_st_t;
endpackage : pie_pkg

// [verilog/pie_sat_counter.sv]
// Eight-bit saturating counter cleared by a read
`timescale 1ns/1ps
`include "pie_cfg.svh"
module pie_sat_counter (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic inc,
	input wire logic clr,
	// State
	output logic [7:0] count,
	output logic half_rise
);
	logic [7:0] count_q;
	logic [7:0] count_d;
	wire at_max = (count_q == `PIE_CNT_MAX);
	wire bump = inc && !at_max;
	// An increment in the clearing cycle is kept as a count of one
	assign count_d = clr ? {7'h00, inc} : (bump ? count_q + 8'h01 : count_q);
	assign half_rise = !count_q[`PIE_CNT_HALF_BIT] && count_d[`PIE_CNT_HALF_BIT];
	assign count = count_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= 8'h00;
		end else begin
			count_q <= count_d;
		end
	end
endmodule : pie_sat_counter

// [verilog/pie_event_sync.sv]
// Two-flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module pie_event_sync (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pin and synchronised level
	input wire logic pin,
	output logic level
);
	logic meta_q;
	logic level_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			meta_q <= pin;
			level_q <= meta_q;
		end
	end
	assign level = level_q;
endmodule : pie_event_sync

// [dv/pie_bank_checker.sv]
// Checker for bus answers, page choice and interrupt of the bank
`timescale 1ns/1ps
`include "pie_cfg.svh"
module pie_bank_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Status
	input wire logic [2:0] bank_choice,
	input wire logic irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire take = hsel && hready && htrans[1];
	wire low = haddr[31:8] == '0;
	wire [5:0] idx = haddr[7:2];
	wire [2:0] wd3 = hwdata[2:0];
	wire wb = take && hwrite && low && idx == `PIE_IDX_BANK;
	sequence s_rd(logic [5:0] i);
		take && !hwrite && low && idx == i;
	endsequence
	sequence s_wr_bank;
		wb ##1 1'b1;
	endsequence
	bus_answer_a: assert property (hreadyout && !hresp)
		else $error("slave stalled or answered with an error");
	bank_write_a: assert property (s_wr_bank |-> ##1 (bank_choice == $past(wd3)))
		else $error("page choice did not take the written value");
	bank_hold_a: assert property ($changed(bank_choice) |-> $past(wb, 2))
		else $error("page choice moved without a write");
	bank_read_a: assert property (s_rd(`PIE_IDX_BANK)
		|=> hrdata == {29'h0000_0000, $past(bank_choice)})
		else $error("page read not zero-filled page choice");
	count_upper_a: assert property ((s_rd(`PIE_IDX_FCC) or s_rd(`PIE_IDX_REC))
		|=> hrdata[31:8] == '0)
		else $error("counter read shows upper bits");
	status_upper_a: assert property (s_rd(`PIE_IDX_ISR) |=> hrdata[31:9] == '0)
		else $error("status read shows bits above the pending flag");
	unmapped_zero_a: assert property (take && !hwrite && !low |=> hrdata == '0)
		else $error("read outside the bank returned data");
	rdata_stand_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	irq_release_a: assert property ($rose(hresetn) |-> !irq)
		else $error("interrupt high straight after reset");
endmodule : pie_bank_checker

bind pie_bank pie_bank_checker pie_bank_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .bank_choice, .irq);

// [dv/pie_host.sv]
// Management host model issuing single-word AHB-Lite transfers
`timescale 1ns/1ps
module pie_host (
	// Clock
	input wire logic hclk,
	// Request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Answer
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
	end

	task xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		// Released data lines must not keep showing the last word
		hwdata <= ~wd;
	endtask : xfer
endmodule : pie_host

// [dv/pie_bank_test.sv]
// Self-checking bench for the interrupt, page and counter bank
`timescale 1ns/1ps
`include "pie_cfg.svh"
module pie_bank_test;
	localparam logic [31:0] a_isr = `PIE_IDX_ISR * 4;
	localparam logic [31:0] a_bank = `PIE_IDX_BANK * 4;
	localparam logic [31:0] a_fcc = `PIE_IDX_FCC * 4;
	localparam logic [31:0] a_rec = `PIE_IDX_REC * 4;
	localparam logic [31:0] a_cfg = `PIE_IDX_CFG * 4;
	localparam logic [31:0] a_mask = `PIE_IDX_IMASK * 4;
	localparam logic [31:0] a_stat = `PIE_IDX_ISTAT * 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, bank;
	// False carrier, rx error, carrier valid, collision, control frame
	logic [4:0] pin = '0;
	// Link quality, energy, link, speed, duplex, time protocol, autoneg
	logic [6:0] evt = '0;
	int enb[7] = '{2, 3, 3, 4, 5, 6, 7};
	int failures = 0;
	int n_compared = 0;

	always #10 hclk = ~hclk;

	pie_host pie_host_i (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata);
	pie_bank pie_bank_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.false_carrier_pin(pin[4]), .rx_error_pin(pin[3]), .carrier_valid_pin(pin[2]),
		.collision_pin(pin[1]), .control_frame_pin(pin[0]),
		.link_quality_evt(evt[6]), .energy_detect_evt(evt[5]), .link_change_evt(evt[4]),
		.speed_change_evt(evt[3]), .duplex_change_evt(evt[2]), .time_protocol_evt(evt[1]),
		.autoneg_done_evt(evt[0]), .bank_choice(bank), .irq);

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wr(input logic [31:0] a, input logic [31:0] d);
		pie_host_i.xfer(1'b1, a, d, rd);
	endtask : wr
	task rd_check(input string w, input logic [31:0] a, input logic [31:0] exp);
		pie_host_i.xfer(1'b0, a, 32'h0000_0000, rd);
		check(w, rd, exp);
	endtask : rd_check
	task idle(input int n);
		repeat (n) @(posedge hclk);
	endtask : idle
	task pulse(input int b, input int n);
		repeat (n) begin
			pin[b] <= 1'b1;
			idle(3);
			pin[b] <= 1'b0;
			idle(3);
		end
	endtask : pulse
	// Two error bursts per carrier, to prove only one is counted
	task carrier(input int n, input logic col);
		repeat (n) begin
			pin[2:1] <= {1'b1, col};
			idle(4);
			pulse(3, 2);
			pin[2:1] <= 2'b00;
			idle(4);
		end
	endtask : carrier
	task wrap_up;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	initial begin
		#600_000;
		failures++;
		wrap_up;
	end

	initial begin
		idle(10);
		hresetn <= 1'b1;
		rd_check("isr reset", a_isr, 32'h0000_0000);
		rd_check("page reset", a_bank, 32'h0000_0000);
		rd_check("fcc reset", a_fcc, 32'h0000_0000);
		rd_check("rec reset", a_rec, 32'h0000_0000);
		for (int v = 0; v < 8; v++) begin
			wr(a_bank, 32'hFFFF_FFF8 | v);
			rd_check("page read", a_bank, v);
			check("page pin", 32'(bank), v);
		end
		wr(32'h0000_00FC, 32'hFFFF_FFFF);
		rd_check("unmapped", 32'h0000_00FC, 32'h0000_0000);
		wr(a_isr, 32'hFFFF_FFFF);
		rd_check("enables", a_isr, 32'h0000_00FF);
		// Upper address bits set: an alias of the status index must not land
		wr(32'h0000_0148, 32'h0000_0000);
		rd_check("out of range", 32'h0000_0148, 32'h0000_0000);
		rd_check("enables kept", a_isr, 32'h0000_00FF);
		wr(a_mask, 32'h0000_00FF);
		$display("test registers done");
		for (int i = 6; i >= 0; i--) begin
			wr(a_isr, 32'h0000_0000);
			wr(a_cfg, (i == 1) ? 32'h0000_0004 : 32'h0000_0000);
			evt[i] <= 1'b1;
			idle(1);
			evt[i] <= 1'b0;
			idle(4);
			check("irq disabled", irq, 1'b0);
			wr(a_isr, 1 << enb[i]);
			idle(1);
			check("irq enabled", irq, 1'b1);
			rd_check("isr events", a_isr, 1 << enb[i]);
			check("irq cleared", irq, 1'b0);
		end
		wr(a_mask, 32'h0000_0000);
		idle(1);
		check("irq sticky", irq, 1'b1);
		pie_host_i.xfer(1'b0, a_stat, 32'h0000_0000, rd);
		check("istat read", rd, 32'h0000_00FC);
		check("irq unstuck", irq, 1'b0);
		wr(a_mask, 32'h0000_00FF);
		$display("test events done");
		wr(a_cfg, 32'h0000_0000);
		wr(a_isr, 32'h0000_0002);
		pulse(4, 5);
		rd_check("fcc count", a_fcc, 32'h0000_0005);
		rd_check("fcc cleared", a_fcc, 32'h0000_0000);
		pulse(4, 127);
		check("fcc below half", irq, 1'b0);
		pulse(4, 1);
		check("fcc half irq", irq, 1'b1);
		rd_check("pending view", `PIE_IDX_EVT * 4, 32'h0000_0002);
		rd_check("isr fcc", a_isr, 32'h0000_0002);
		check("fcc irq clr", irq, 1'b0);
		pulse(4, 130);
		rd_check("fcc stick", a_fcc, 32'h0000_00FF);
		$display("test false carrier done");
		wr(a_isr, 32'h0000_0001);
		carrier(1, 1'b0);
		rd_check("rec once", a_rec, 32'h0000_0001);
		carrier(1, 1'b1);
		pulse(3, 2);
		rd_check("rec blocked", a_rec, 32'h0000_0000);
		carrier(128, 1'b0);
		check("rec half irq", irq, 1'b1);
		rd_check("isr rec", a_isr, 32'h0000_0101);
		rd_check("isr rec clr", a_isr, 32'h0000_0001);
		carrier(200, 1'b0);
		rd_check("rec stick", a_rec, 32'h0000_00FF);
		wr(a_cfg, 32'h0000_0001);
		pulse(0, 1);
		check("frame irq", irq, 1'b1);
		rd_check("isr frame", a_isr, 32'h0000_0101);
		rd_check("isr frame clr", a_isr, 32'h0000_0001);
		// Control-frame config alone: slot 1 follows either counter half-full
		wr(a_cfg, 32'h0000_0008);
		rd_check("config", a_cfg, 32'h0000_0008);
		wr(a_isr, 32'h0000_0002);
		carrier(128, 1'b0);
		check("either half irq", irq, 1'b1);
		rd_check("isr either", a_isr, 32'h0000_0102);
		$display("test receive errors done");
		wrap_up;
	end
endmodule : pie_bank_test
